// [logic/bprs_pkg.sv]
package bprs_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_KHZ      = 100000;
  localparam int unsigned PERST_MS     = 100;
  localparam int unsigned PDOWN_MS     = 100;
  localparam int unsigned CNT_W        = 24;
  localparam logic [CNT_W-1:0] PERST_CYC = CNT_W'(PERST_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] PDOWN_CYC = CNT_W'(PDOWN_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int unsigned NSLOT   = 8;
  localparam int unsigned SYNC_W  = NSLOT + 5;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic main_12v;
    logic rail_3v3;
    logic retimer_regulator;
  } bprs_rail_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_RUN, ST_PD_RST, ST_PD_WAIT, ST_PD_CLK, ST_PD_RAIL, ST_FAULT
  } bprs_state_t;

endpackage

// [logic/bprs_sequencer.sv]
`timescale 1ns/100ps
module bprs_sequencer
  import bprs_pkg::*;
#(
  parameter bit                    HAS_RETIMER = 1'b1,
  parameter logic [CNT_W-1:0]      T_PERST     = bprs_pkg::PERST_CYC,
  parameter logic [CNT_W-1:0]      T_PDOWN     = bprs_pkg::PDOWN_CYC
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                power_cmd,
  input  wire bprs_pkg::bprs_rail_t rail_cmd,
  input  wire logic                fault_clear,
  input  wire bprs_pkg::bprs_rail_t rail_good_in,
  input  wire logic [7:0]          slot_supply_good_in,
  input  wire logic                host_perst_n,
  input  wire logic                power_break_n,
  output bprs_pkg::bprs_rail_t     rail_on,
  output logic                     rail_3v3_on,
  output logic                     module_enable,
  output logic                     board_power_request_n,
  output logic [7:0]               refclk_buf_en,
  output logic [7:0]               slot_perst_n,
  output logic [7:0]               slot_power_break_n,
  output logic [7:0]               warm_restart_n_o,
  output logic [7:0]               warm_restart_n_oe,
  output logic                     fault
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  wire  [SYNC_W-1:0] pins = {rail_good_in, slot_supply_good_in, host_perst_n, power_break_n};

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire bprs_rail_t rgood_s  = sync2_r[SYNC_W-1 -: 3];
  wire [7:0]       sgood_s  = sync2_r[NSLOT+1:2];
  wire             hperst_s = sync2_r[1];
  wire             pbrk_s   = sync2_r[0];

  // ***************************************************************
  // rail decode
  // ***************************************************************
  // retimer rail masked out entirely when not fitted
  wire bprs_rail_t present = '{main_12v: 1'b1, rail_3v3: 1'b1, retimer_regulator: HAS_RETIMER};
  wire             rails_good = &(rgood_s | ~present);

  bprs_state_t state_r;
  bprs_state_t state_nxt;
  logic [7:0]  tmo_slot;
  logic [7:0]  rel_r;
  logic        fault_r;

  wire rails_live = (state_r == ST_RAMP) || (state_r == ST_RUN) || (state_r == ST_PD_RST) ||
                    (state_r == ST_PD_WAIT) || (state_r == ST_PD_CLK);
  // clocks run with the ramp, stop one step before rails, or with them on a timeout fault
  wire clk_live   = (state_r == ST_RAMP) || (state_r == ST_RUN) || (state_r == ST_PD_RST) ||
                    (state_r == ST_PD_WAIT);
  wire moden      = (state_r == ST_RUN) || (state_r == ST_PD_RST);
  wire any_good   = |sgood_s;
  wire any_tmo    = |tmo_slot;

  // ***************************************************************
  // main sequence
  // ***************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF:     if (power_cmd) state_nxt = ST_RAMP;
      ST_RAMP: begin
        if (!power_cmd) state_nxt = ST_PD_CLK;
        else if (rails_good) state_nxt = ST_RUN;
      end
      ST_RUN:     if (!power_cmd || !rails_good) state_nxt = ST_PD_RST;
      ST_PD_RST:  state_nxt = ST_PD_WAIT;
      ST_PD_WAIT: begin
        if (any_tmo) state_nxt = ST_FAULT;
        else if (!any_good) state_nxt = ST_PD_CLK;
      end
      ST_PD_CLK:  state_nxt = ST_PD_RAIL;
      ST_PD_RAIL: state_nxt = ST_OFF;
      ST_FAULT:   if (!power_cmd) state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // ***************************************************************
  // per-slot timers
  // ***************************************************************
  logic [CNT_W-1:0] cnt_r [NSLOT];

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      // one counter serves both waits; it restarts on every state change
      wire counting = sgood_s[g] && (state_r == state_nxt) &&
                      ((state_r == ST_RUN) || (state_r == ST_PD_WAIT));
      wire [CNT_W-1:0] lim = (state_r == ST_RUN) ? T_PERST : T_PDOWN;
      wire hit = (cnt_r[g] >= lim);
      // carry out dropped on purpose; the count saturates at its limit far below the top
      wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_r[g] + CNT_ONE);
      wire [CNT_W-1:0] cnt_nxt = !counting ? CNT_ZERO : (hit ? cnt_r[g] : cnt_inc);
      // release drops on the edge that leaves run, so power-down opens with every slot in reset
      wire stay_run = (state_r == ST_RUN) && (state_nxt == ST_RUN);
      wire rel_nxt = stay_run && sgood_s[g] && (rel_r[g] || hit);
      assign tmo_slot[g] = (state_r == ST_PD_WAIT) && sgood_s[g] && hit;

      always_ff @(posedge mclk) begin
        if (!resetn) begin
          cnt_r[g] <= CNT_ZERO;
          rel_r[g] <= 1'b0;
        end else begin
          cnt_r[g] <= cnt_nxt;
          rel_r[g] <= rel_nxt;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // fault flag
  // ***************************************************************
  // a new timeout beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn) fault_r <= 1'b0;
    else fault_r <= (state_r == ST_PD_WAIT && any_tmo) || (fault_r && !fault_clear);
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  wire [7:0] perst_rel = rel_r & {NSLOT{hperst_s}};

  assign rail_on.main_12v          = rails_live && rail_cmd.main_12v;
  assign rail_on.rail_3v3          = rails_live && rail_cmd.rail_3v3;
  assign rail_on.retimer_regulator = rails_live && rail_cmd.retimer_regulator && HAS_RETIMER;
  assign rail_3v3_on               = rail_on.rail_3v3;
  assign module_enable             = moden;
  assign board_power_request_n     = !moden;
  assign refclk_buf_en             = {NSLOT{clk_live}};
  assign slot_perst_n              = perst_rel;
  assign slot_power_break_n        = {NSLOT{pbrk_s}};
  // open drain: warm restart follows the same release, so never earlier
  assign warm_restart_n_o          = 8'h00;
  assign warm_restart_n_oe         = ~perst_rel;
  assign fault                     = fault_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_clk_stop;
    (refclk_buf_en == 8'h00) && rail_3v3_on;
  endsequence
  sequence s_rails_down;
    (state_r == ST_PD_RAIL) && !rail_3v3_on ##1 (state_r == ST_OFF);
  endsequence

  AST_MODEN_GOOD: assert property ($rose(module_enable) |-> $past(rails_good))
    else $error("module enable rose without good rails");
  AST_MODEN_RAILS: assert property (module_enable |-> rails_live)
    else $error("module enable high with rails off");
  AST_NO_RETIMER: assert property (!HAS_RETIMER |-> !rail_on.retimer_regulator)
    else $error("absent retimer rail enabled");
  AST_CLK_RAMP: assert property (state_r == ST_RAMP |-> refclk_buf_en == 8'hff)
    else $error("clocks off during ramp");
  AST_PERST_WAIT: assert property ($rose(slot_perst_n[0]) |-> $past(cnt_r[0]) >= T_PERST)
    else $error("slot reset released early");
  AST_WARM_ORDER: assert property (!warm_restart_n_oe[0] |-> slot_perst_n[0])
    else $error("warm restart released before slot reset");
  AST_CLK_FIRST: assert property ((state_r == ST_PD_CLK) && rail_cmd.rail_3v3 |-> s_clk_stop ##1 s_rails_down)
    else $error("3v3 dropped before clocks stopped");
  AST_TMO_FAULT: assert property ((state_r == ST_PD_WAIT) && any_tmo |=> fault && rail_on == '0)
    else $error("timeout did not shut rails and flag fault");
  AST_FANOUT: assert property (!hperst_s |-> slot_perst_n == 8'h00)
    else $error("host reset not fanned out");
  AST_PD_ORDER: assert property ($fell(module_enable) |-> $past(slot_perst_n) == 8'h00 && refclk_buf_en == 8'hff)
    else $error("module enable dropped before resets");
  // power-down opens with resets low while modules still see board power-good
  AST_PD_RESETS: assert property ((state_r == ST_PD_RST) |-> (slot_perst_n == 8'h00) && module_enable)
    else $error("module enable held without slot resets asserted");
  // idle means no rail, clock or module enable is driven toward the modules
  AST_IDLE_OFF: assert property ((state_r == ST_OFF) |->
    (rail_on == '0) && (refclk_buf_en == 8'h00) && !module_enable)
    else $error("rail, clock or module enable on while idle");
  // each slot's release rests on its own supply-good and its own timer
  AST_SLOT_OWN: assert property (slot_perst_n[1] |-> $past(sgood_s[1]))
    else $error("slot released without its own supply good");
  AST_SLOT_LAST: assert property ($rose(slot_perst_n[7]) |-> $past(cnt_r[7]) >= T_PERST)
    else $error("last slot reset released early");
  // a clear with no new timeout empties the flag on the next edge
  AST_FAULT_CLR: assert property (fault && fault_clear && !any_tmo |=> !fault)
    else $error("fault flag ignored its clear");

endmodule // bprs_sequencer

// [sim/bprs_partner.sv]
`timescale 1ns/100ps
// ******************************************
// far side: rails and eight module slots
// ******************************************
module bprs_partner
  import bprs_pkg::*;
(
  input  wire logic                 mclk,
  input  wire bprs_pkg::bprs_rail_t rail_on,
  input  wire logic                 module_enable,
  input  wire logic [7:0]           slot_hold,
  output bprs_pkg::bprs_rail_t      rail_good_in,
  output logic [7:0]                slot_supply_good_in
);
  logic [7:0] up_cnt [8];
  // each rail reports good one cycle after its enable
  always_ff @(posedge mclk) begin
    rail_good_in <= rail_on;
  end
  // slot i comes good 4*i+2 cycles after board power-good, staggered to split the timers
  // slot_hold keeps a good stuck high, the faulty module the bench asks for
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 8; i++) begin
      up_cnt[i] <= (module_enable !== 1'b1) ? 8'h00 : (up_cnt[i] == 8'hff ? up_cnt[i] : up_cnt[i] + 8'h01);
      slot_supply_good_in[i] <= (module_enable === 1'b1 && up_cnt[i] > 8'(4 * i)) || (slot_hold[i] && slot_supply_good_in[i]);
    end
  end
endmodule // bprs_partner

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
  import bprs_pkg::*;
  localparam logic [CNT_W-1:0] T_SIM = CNT_W'(20);
  logic       mclk = 1'b0, resetn = 1'b0, power_cmd = 1'b0, fault_clear = 1'b0, host_perst_n = 1'b1, power_break_n = 1'b1;
  bprs_rail_t rail_cmd = '1, rail_good_in, rail_on;
  logic [7:0] slot_hold = '0, slot_supply_good_in, refclk_buf_en, slot_perst_n, slot_power_break_n;
  logic [7:0] warm_restart_n_o, warm_restart_n_oe;
  logic       rail_3v3_on, module_enable, board_power_request_n, fault;
  int         fail_count = 0, cmp_count = 0, cyc = 0;
  always #5 mclk = ~mclk;
  // short counts keep the 100 ms waits to 20 cycles
  bprs_sequencer #(.T_PERST(T_SIM), .T_PDOWN(T_SIM)) i_bprs_sequencer (.mclk, .resetn, .power_cmd, .rail_cmd,
    .fault_clear, .rail_good_in, .slot_supply_good_in, .host_perst_n, .power_break_n, .rail_on, .rail_3v3_on,
    .module_enable, .board_power_request_n, .refclk_buf_en, .slot_perst_n, .slot_power_break_n,
    .warm_restart_n_o, .warm_restart_n_oe, .fault);
  bprs_partner i_bprs_partner (.mclk, .rail_on, .module_enable, .slot_hold, .rail_good_in, .slot_supply_good_in);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // cut a hang short; the run needs under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ******************************************
  // scenarios
  // ******************************************
  task automatic power_up();
    int gc [8] = '{default: 0};
    int rel [8] = '{default: -1};
    @(negedge mclk) power_cmd = 1'b1;
    repeat (300) begin
      @(negedge mclk);
      if (rail_on.rail_3v3 === 1'b1) check("refclk_ramp", refclk_buf_en, 8'hff);
      check("moden_good", {7'h0, module_enable & ~&rail_good_in}, 8'h00);
      check("warm_rel", warm_restart_n_oe, ~slot_perst_n);
      for (int i = 0; i < 8; i++) begin
        if (slot_supply_good_in[i] === 1'b1) gc[i]++;
        if (slot_perst_n[i] === 1'b1 && rel[i] < 0) rel[i] = gc[i];
      end
      if (slot_perst_n === 8'hff) break;
    end
    check("req_n", {7'h0, board_power_request_n}, 8'h00);
    for (int i = 0; i < 8; i++) check("perst_gap", 8'(rel[i] >= 20 && rel[i] <= 26), 8'h01);
    $display("test power_up done");
  endtask
  task automatic fanout();
    @(negedge mclk) host_perst_n = 1'b0;
    power_break_n = 1'b0;
    repeat (4) @(negedge mclk);
    check("perst_fan", slot_perst_n, 8'h00);
    check("warm_fan", warm_restart_n_oe, 8'hff);
    check("warm_low", warm_restart_n_o, 8'h00);
    check("brk_fan", slot_power_break_n, 8'h00);
    host_perst_n = 1'b1;
    power_break_n = 1'b1;
    repeat (4) @(negedge mclk);
    check("perst_back", slot_perst_n, 8'hff);
    check("brk_back", slot_power_break_n, 8'hff);
    $display("test fanout done");
  endtask
  task automatic power_down();
    int t_me = -1, t_clk = -1, t_rail = -1;
    @(negedge mclk) power_cmd = 1'b0;
    for (int n = 0; n < 100; n++) begin
      @(negedge mclk);
      if (module_enable === 1'b0 && t_me < 0) begin
        t_me = n;
        check("perst_first", slot_perst_n | ~warm_restart_n_oe, 8'h00);
      end
      if (refclk_buf_en === 8'h00 && t_clk < 0) t_clk = n;
      if (rail_3v3_on === 1'b0 && t_rail < 0) t_rail = n;
    end
    check("pd_order", 8'(t_me >= 0 && t_me < t_clk && t_clk < t_rail), 8'h01);
    check("req_n_off", {7'h0, board_power_request_n}, 8'h01);
    $display("test power_down done");
  endtask
  task automatic fault_path();
    int n = 0;
    @(negedge mclk) slot_hold = 8'h08;
    power_up();
    @(negedge mclk) power_cmd = 1'b0;
    fault_clear = 1'b1; // held over the timeout edge: the set must still win
    while (module_enable === 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (fault !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check("fault_time", 8'(n >= 19 && n <= 26), 8'h01);
    check("fault_rails", {5'h0, rail_on}, 8'h00);
    check("fault_clk", refclk_buf_en, 8'h00);
    @(negedge mclk) slot_hold = 8'h00;
    fault_clear = 1'b1;
    @(negedge mclk) fault_clear = 1'b0;
    repeat (5) @(negedge mclk);
    check("fault_clr", {7'h0, fault}, 8'h00);
    $display("test fault_path done");
  endtask
  task automatic rail_drop();
    int n = 0;
    power_up();
    @(negedge mclk) rail_cmd.main_12v = 1'b0;
    #1 check("rail_cmd", {7'h0, rail_on.main_12v}, 8'h00);
    while (module_enable === 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    check("rail_loss", {7'h0, module_enable}, 8'h00);
    power_cmd = 1'b0;
    rail_cmd = '1;
    repeat (60) @(negedge mclk);
    $display("test rail_drop done");
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    power_up();
    fanout();
    power_down();
    fault_path();
    rail_drop();
    report_and_stop();
  end
endmodule // tb
